/* hdl/rcp_pkg.sv */
// Notes on behaviour
// R1: Radio core clock ticks only while radio_core_clk_en is set.
// R2: Low-power timer reset output follows lowpower_timer_rst, which resets to one.
// R3: Radio core clock divides by 1, 2, 4 or 8 per radio_core_div.
// R4: Software keeps radio core clock between 8 MHz and the processor clock.
// R5: RF control unit clock ticks only while rf_ctrl_unit_clk_en is set.
// R6: RF control unit clock divides by 1, 2, 4 or 8 per rf_ctrl_unit_div.
// R7: Software picks rf_ctrl_unit_div so the RF control unit sees 8 MHz.
// R8: Each ret_ram_keep_mask bit keeps its retention bank powered; zero gates it.
// R9: While OTP is mirrored, the bus clock uses mirror_bus_div.
// R10: Radio digital domain is powered down while radio_domain_down is set.
// R11: Peripheral domain is powered down while periph_domain_down is set.
// R12: With reboot_after_wake set, waking issues a full hardware reset.
// R13: Writing one to soft_chip_reset resets all except system control and trim.
// R14: Power sequence proceeds after 2 ms unless power_fsm_timeout_off; outcome readable.
// R15: With debug_port_on clear, debug pins are released for general use.
// R16: otp_ctrl_rst_req drives the OTP controller reset request.
// R17: pin_state_hold_n zero holds pad controls; one makes the latch transparent.
// R18: With otp_mirror_on set, OTP is copied to RAM after system wake.
// R19: slow_clk_sel picks the RC oscillator at 0, the crystal at 1.
// R20: No wake copy when keep_system_ram is set; system control survives soft reset.
// R21: Divider and enable changes take effect only at a period boundary.
package rcp_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [31:0] RADIO_CLOCK_CTRL_OFS  = 32'h0500_0008;
  localparam logic [31:0] POWER_UNIT_CTRL_OFS   = 32'h5000_0010;
  localparam logic [31:0] SYSTEM_CTRL_OFS       = 32'h5000_0012;
  localparam logic [31:0] ANALOG_STATUS_OFS     = 32'h5000_0018;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int RC_CORE_EN_B      = 7;
  localparam int RC_LPT_RST_B      = 6;
  localparam int RC_CORE_DIV_LSB   = 4;
  localparam int RC_RFCU_EN_B      = 3;
  localparam int RC_RF_CTRL_UNIT_DIV_LSB   = 0;
  localparam int PU_KEEP_LSB       = 8;
  localparam int PU_MDIV_LSB       = 4;
  localparam int PU_RADIO_DN_B     = 2;
  localparam int PU_PERIPH_DN_B    = 1;
  localparam int PU_REBOOT_B       = 0;
  localparam int SC_SOFT_RST_B     = 15;
  localparam int SC_TMO_OFF_B      = 9;
  localparam int SC_DBG_B          = 7;
  localparam int SC_OTPC_RST_B     = 6;
  localparam int SC_PIN_HOLD_N_B   = 5;
  localparam int SC_MIRROR_B       = 4;
  localparam int SC_SLOW_SEL_B     = 3;
  localparam int SC_KEEP_SYSRAM_B  = 2;
  localparam int AS_PWR_OK_B       = 0;
  localparam int AS_PWR_TMO_B      = 1;
  localparam int AS_PWR_WAIT_B     = 2;
  localparam int AS_MIRROR_B       = 3;

  // ****************************************************************
  // Reset values and writable bits
  // ****************************************************************
  localparam logic [15:0] RADIO_CLOCK_CTRL_RST = 16'h0040;
  localparam logic [15:0] POWER_UNIT_CTRL_RST  = 16'h0006;
  localparam logic [15:0] SYSTEM_CTRL_RST      = 16'h0020;
  localparam logic [15:0] RC_WMASK             = 16'h00fb;
  localparam logic [15:0] PU_WMASK             = 16'h0f37;
  localparam logic [15:0] SC_WMASK             = 16'h02fc;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned MCLK_KHZ            = 10000;
  localparam int unsigned PWR_TIMEOUT_US      = 2000;
  localparam int unsigned PWR_TIMEOUT_CYC_DEF = PWR_TIMEOUT_US * MCLK_KHZ / 1000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } rcp_bus_req_s;

  typedef struct packed {
    logic [3:0] ret_keep;
    logic       radio_down;
    logic       periph_down;
    logic       lp_timer_rst;
  } rcp_pwr_s;

  typedef enum logic [2:0] {
    PF_IDLE = 3'b001,
    PF_WAIT = 3'b010,
    PF_DONE = 3'b100
  } rcp_pfsm_e;

endpackage

/* hdl/rcp_ctrl.sv */
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module rcp_ctrl
#(
  parameter int unsigned PWR_TIMEOUT_CYC = rcp_pkg::PWR_TIMEOUT_CYC_DEF,
  parameter int unsigned TMO_W           = 16
)
(
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire rcp_pkg::rcp_bus_req_s bus_req,
  input  wire logic                 pwr_seq_start,
  input  wire logic                 pwr_blocks_up,
  input  wire logic                 sys_wake,
  input  wire logic                 mirror_done,
  output logic [15:0]               rdata,
  output logic                      core_clk_tick,
  output logic                      rf_clk_tick,
  output rcp_pkg::rcp_pwr_s         pwr,
  output logic                      mirror_busy,
  output logic [1:0]                mirror_bus_div,
  output logic                      pwr_proceed,
  output logic                      soft_rst_pulse,
  output logic                      hw_rst_pulse,
  output logic                      debug_port_on,
  output logic                      otp_ctrl_rst_req,
  output logic                      pin_state_hold_n,
  output logic                      slow_clk_sel
);
  import rcp_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [15:0]      radio_ctrl;
    logic [15:0]      pmu_ctrl;
    logic [15:0]      sys_ctrl;
    logic [15:0]      rdata;
    logic [1:0][2:0]  div_cnt;
    logic [1:0][1:0]  div_app;
    logic [1:0]       en_app;
    logic [1:0]       tick;
    rcp_pfsm_e        pfsm;
    logic [TMO_W-1:0] tmo_cnt;
    logic             pwr_ok;
    logic             pwr_tmo;
    logic             mirror_busy;
    logic             soft_rst;
    logic             hw_rst;
  } rcp_state_s;

  localparam rcp_state_s ST_RST = '{
    radio_ctrl:  RADIO_CLOCK_CTRL_RST,
    pmu_ctrl:    POWER_UNIT_CTRL_RST,
    sys_ctrl:    SYSTEM_CTRL_RST,
    rdata:       16'h0000,
    div_cnt:     6'h00,
    div_app:     4'h0,
    en_app:      2'h0,
    tick:        2'h0,
    pfsm:        PF_IDLE,
    tmo_cnt:     '0,
    pwr_ok:      1'b0,
    pwr_tmo:     1'b0,
    mirror_busy: 1'b0,
    soft_rst:    1'b0,
    hw_rst:      1'b0
  };

  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(PWR_TIMEOUT_CYC - 1);

  rcp_state_s      q;
  rcp_state_s      n;
  logic [1:0]      req_en;
  logic [1:0][1:0] req_div;
  logic            wr_rc;
  logic            wr_pu;
  logic            wr_sc;
  logic            soft_req;
  logic            copy_ok;
  logic [15:0]     status;

  function automatic logic [2:0] div_limit(input logic [1:0] code);
    logic [3:0] p;
    p = 4'h1 << code;
    return 3'(p - 4'h1);
  endfunction

  // ****************************************************************
  // Decode
  // ****************************************************************
  assign req_en[0]  = q.radio_ctrl[RC_CORE_EN_B];
  assign req_en[1]  = q.radio_ctrl[RC_RFCU_EN_B];
  assign req_div[0] = q.radio_ctrl[RC_CORE_DIV_LSB +: 2];
  assign req_div[1] = q.radio_ctrl[RC_RF_CTRL_UNIT_DIV_LSB +: 2];
  assign wr_rc      = bus_req.wr && (bus_req.addr == RADIO_CLOCK_CTRL_OFS);
  assign wr_pu      = bus_req.wr && (bus_req.addr == POWER_UNIT_CTRL_OFS);
  assign wr_sc      = bus_req.wr && (bus_req.addr == SYSTEM_CTRL_OFS);
  // R13: soft reset strobe
  assign soft_req   = wr_sc && bus_req.wdata[SC_SOFT_RST_B];
  // R18: copy allowed on wake
  // R20: no copy when system RAM kept
  assign copy_ok    = q.sys_ctrl[SC_MIRROR_B] && !q.sys_ctrl[SC_KEEP_SYSRAM_B];

  // R14: startup outcome readable
  always_comb
  begin
    status                = 16'h0000;
    status[AS_PWR_OK_B]   = q.pwr_ok;
    status[AS_PWR_TMO_B]  = q.pwr_tmo;
    status[AS_PWR_WAIT_B] = (q.pfsm == PF_WAIT);
    status[AS_MIRROR_B]   = q.mirror_busy;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    n          = q;
    n.tick     = 2'h0;
    n.rdata    = 16'h0000;
    n.soft_rst = 1'b0;
    n.hw_rst   = 1'b0;

    // R21: settings change only at period end
    for (int i = 0; i < 2; i++)
    begin
      if (q.div_cnt[i] == div_limit(q.div_app[i]))
      begin
        n.div_cnt[i] = 3'h0;
        // R3: core divide code applied
        // R6: RF unit divide code applied
        n.div_app[i] = req_div[i];
        n.en_app[i]  = req_en[i];
        // R1: core clock gated by enable
        // R5: RF unit clock gated by enable
        n.tick[i]    = req_en[i];
      end
      else
      begin
        n.div_cnt[i] = q.div_cnt[i] + 3'h1;
      end
    end

    // Register writes
    if (wr_rc)
    begin
      n.radio_ctrl = bus_req.wdata & RC_WMASK;
    end
    if (wr_pu)
    begin
      n.pmu_ctrl = bus_req.wdata & PU_WMASK;
    end
    if (wr_sc)
    begin
      n.sys_ctrl = bus_req.wdata & SC_WMASK;
    end

    // Register reads, unmapped reads give zero
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        RADIO_CLOCK_CTRL_OFS: n.rdata = q.radio_ctrl;
        POWER_UNIT_CTRL_OFS:  n.rdata = q.pmu_ctrl;
        SYSTEM_CTRL_OFS:      n.rdata = q.sys_ctrl;
        ANALOG_STATUS_OFS:    n.rdata = status;
        default:              n.rdata = 16'h0000;
      endcase
    end

    // R14: power sequence timeout
    case (q.pfsm)
      PF_IDLE:
      begin
        if (pwr_seq_start)
        begin
          n.pfsm    = PF_WAIT;
          n.tmo_cnt = '0;
          n.pwr_ok  = 1'b0;
          n.pwr_tmo = 1'b0;
        end
      end
      PF_WAIT:
      begin
        if (pwr_blocks_up)
        begin
          n.pfsm   = PF_DONE;
          n.pwr_ok = 1'b1;
        end
        else if (q.tmo_cnt >= TMO_LAST)
        begin
          if (!q.sys_ctrl[SC_TMO_OFF_B])
          begin
            n.pfsm    = PF_DONE;
            n.pwr_tmo = 1'b1;
          end
        end
        else
        begin
          n.tmo_cnt = q.tmo_cnt + TMO_W'(1);
        end
      end
      PF_DONE:
      begin
        if (pwr_seq_start)
        begin
          n.pfsm    = PF_WAIT;
          n.tmo_cnt = '0;
          n.pwr_ok  = 1'b0;
          n.pwr_tmo = 1'b0;
        end
      end
      default:
      begin
        n.pfsm = PF_IDLE;
      end
    endcase

    // OTP mirror tracking, a wake wins over a done in the same cycle
    if (mirror_done)
    begin
      n.mirror_busy = 1'b0;
    end
    if (sys_wake)
    begin
      // R12: reboot on wake
      if (q.pmu_ctrl[PU_REBOOT_B])
      begin
        n.hw_rst = 1'b1;
      end
      // R18: start OTP copy
      else if (copy_ok)
      begin
        n.mirror_busy = 1'b1;
      end
    end

    // R13: soft reset spares system control
    // R20: system control kept
    if (soft_req)
    begin
      n.radio_ctrl  = RADIO_CLOCK_CTRL_RST;
      n.pmu_ctrl    = POWER_UNIT_CTRL_RST;
      n.div_cnt     = ST_RST.div_cnt;
      n.div_app     = ST_RST.div_app;
      n.en_app      = ST_RST.en_app;
      n.tick        = 2'h0;
      n.pfsm        = PF_IDLE;
      n.tmo_cnt     = '0;
      n.pwr_ok      = 1'b0;
      n.pwr_tmo     = 1'b0;
      n.mirror_busy = 1'b0;
      n.soft_rst    = 1'b1;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= ST_RST;
    end
    else
    begin
      q <= n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata            = q.rdata;
  assign core_clk_tick    = q.tick[0];
  assign rf_clk_tick      = q.tick[1];
  // R8: retention bank keep mask
  assign pwr.ret_keep     = q.pmu_ctrl[PU_KEEP_LSB +: 4];
  // R10: radio domain power down
  assign pwr.radio_down   = q.pmu_ctrl[PU_RADIO_DN_B];
  // R11: peripheral domain power down
  assign pwr.periph_down  = q.pmu_ctrl[PU_PERIPH_DN_B];
  // R2: low-power timer reset
  assign pwr.lp_timer_rst = q.radio_ctrl[RC_LPT_RST_B];
  assign mirror_busy      = q.mirror_busy;
  // R9: bus divide during mirroring
  assign mirror_bus_div   = q.pmu_ctrl[PU_MDIV_LSB +: 2];
  // One-hot done bit, taken straight from the state flop
  assign pwr_proceed      = q.pfsm[2];
  assign soft_rst_pulse   = q.soft_rst;
  assign hw_rst_pulse     = q.hw_rst;
  // R15: debug pins claimed only when set
  assign debug_port_on    = q.sys_ctrl[SC_DBG_B];
  // R16: OTP controller reset request
  assign otp_ctrl_rst_req = q.sys_ctrl[SC_OTPC_RST_B];
  // R17: pad latch control
  assign pin_state_hold_n = q.sys_ctrl[SC_PIN_HOLD_N_B];
  // R19: slow clock source
  assign slow_clk_sel     = q.sys_ctrl[SC_SLOW_SEL_B];

endmodule

/* verification/rcp_ctrl_asserts.sv */
`timescale 1ns/1ps
module rcp_ctrl_asserts
#(
  parameter int unsigned PWR_TIMEOUT_CYC = rcp_pkg::PWR_TIMEOUT_CYC_DEF
)
(
  input wire logic                  mclk,
  input wire logic                  resetn,
  input wire rcp_pkg::rcp_bus_req_s bus_req,
  input wire logic                  pwr_seq_start,
  input wire logic                  pwr_blocks_up,
  input wire logic                  sys_wake,
  input wire logic                  mirror_done,
  input wire logic [15:0]           rdata,
  input wire logic                  core_clk_tick,
  input wire logic                  rf_clk_tick,
  input wire rcp_pkg::rcp_pwr_s     pwr,
  input wire logic                  mirror_busy,
  input wire logic [1:0]            mirror_bus_div,
  input wire logic                  pwr_proceed,
  input wire logic                  soft_rst_pulse,
  input wire logic                  hw_rst_pulse,
  input wire logic                  debug_port_on,
  input wire logic                  otp_ctrl_rst_req,
  input wire logic                  pin_state_hold_n,
  input wire logic                  slow_clk_sel
);
  import rcp_pkg::*;

  logic [15:0] sc_q;
  logic        boot_q;
  logic        w_rc;
  logic        w_sc;
  int unsigned wait_cnt;

  assign w_rc = bus_req.wr && bus_req.addr == RADIO_CLOCK_CTRL_OFS;
  assign w_sc = bus_req.wr && bus_req.addr == SYSTEM_CTRL_OFS;

  // Shadow of the bits that steer wake handling
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sc_q   <= SYSTEM_CTRL_RST;
      boot_q <= 1'b0;
    end
    else
    begin
      if (w_sc)
        sc_q <= bus_req.wdata & SC_WMASK;
      if (w_sc && bus_req.wdata[15])
        boot_q <= 1'b0;
      else if (bus_req.wr && bus_req.addr == POWER_UNIT_CTRL_OFS)
        boot_q <= bus_req.wdata[0];
    end
  end

  // Cycles spent waiting since the last start; restarts while timeout is off
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      wait_cnt <= 0;
    else if (pwr_seq_start || (sc_q[9] && wait_cnt != 0))
      wait_cnt <= 1;
    else if (soft_rst_pulse || pwr_proceed)
      wait_cnt <= 0;
    else if (wait_cnt != 0)
      wait_cnt <= wait_cnt + 1;
  end

  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  a_sys_readback : assert property (
    bus_req.rd && bus_req.addr == SYSTEM_CTRL_OFS |=> rdata[15] == 1'b0
    && rdata[7:5] == {debug_port_on, otp_ctrl_rst_req, pin_state_hold_n}
    && rdata[3] == slow_clk_sel)
    else $error("system control readback differs from outputs");
  a_pwr_readback : assert property (
    bus_req.rd && bus_req.addr == POWER_UNIT_CTRL_OFS |=> rdata[11:8] == pwr.ret_keep
    && rdata[5:4] == mirror_bus_div && rdata[2:1] == {pwr.radio_down, pwr.periph_down})
    else $error("power control readback differs from outputs");
  a_soft_reset : assert property (
    w_sc && bus_req.wdata[15] |=> soft_rst_pulse && pwr == 7'h07
    && debug_port_on == $past(bus_req.wdata[7]))
    else $error("soft reset effect wrong");
  a_core_off : assert property (
    w_rc && !bus_req.wdata[7] ##1 (!w_rc) [*8] |-> ##3 !core_clk_tick)
    else $error("core tick while disabled");
  a_rf_off : assert property (
    w_rc && !bus_req.wdata[3] ##1 (!w_rc) [*8] |-> ##3 !rf_clk_tick)
    else $error("rf tick while disabled");
  a_core_div1 : assert property (
    w_rc && bus_req.wdata[7] && bus_req.wdata[5:4] == 2'h0 ##1 (!w_rc) [*8]
    |-> ##3 core_clk_tick [*3])
    else $error("core divide by one not every cycle");
  a_rf_div8 : assert property (
    w_rc && bus_req.wdata[3] && bus_req.wdata[1:0] == 2'h3 ##1 (!w_rc) [*8]
    ##[3:10] rf_clk_tick |=> !rf_clk_tick [*7] ##1 rf_clk_tick)
    else $error("rf divide by eight period wrong");
  a_start_clears : assert property (
    pwr_seq_start && pwr_proceed |=> !pwr_proceed)
    else $error("start did not clear proceed");
  a_blocks_fast : assert property (
    pwr_seq_start ##1 pwr_blocks_up |=> pwr_proceed)
    else $error("proceed late after blocks up");
  a_tmo_bound : assert property (
    wait_cnt <= PWR_TIMEOUT_CYC + 2)
    else $error("power sequence waited past timeout");
  a_wake_reboot : assert property (
    sys_wake |=> hw_rst_pulse == $past(boot_q))
    else $error("hardware reset on wake wrong");
  a_wake_mirror : assert property (
    sys_wake && !boot_q && sc_q[4] && !sc_q[2] |=> mirror_busy)
    else $error("copy on wake not started");

  c_mirror : cover property (mirror_busy ##1 !mirror_busy);
  c_reboot : cover property (hw_rst_pulse);
  c_soft   : cover property (soft_rst_pulse);
endmodule

bind rcp_ctrl rcp_ctrl_asserts #(.PWR_TIMEOUT_CYC(PWR_TIMEOUT_CYC)) asserts_u (
  .mclk(mclk), .resetn(resetn), .bus_req(bus_req), .pwr_seq_start(pwr_seq_start),
  .pwr_blocks_up(pwr_blocks_up), .sys_wake(sys_wake), .mirror_done(mirror_done),
  .rdata(rdata), .core_clk_tick(core_clk_tick), .rf_clk_tick(rf_clk_tick), .pwr(pwr),
  .mirror_busy(mirror_busy), .mirror_bus_div(mirror_bus_div), .pwr_proceed(pwr_proceed),
  .soft_rst_pulse(soft_rst_pulse), .hw_rst_pulse(hw_rst_pulse),
  .debug_port_on(debug_port_on), .otp_ctrl_rst_req(otp_ctrl_rst_req),
  .pin_state_hold_n(pin_state_hold_n), .slow_clk_sel(slow_clk_sel));

/* verification/rcp_ctrl_bench.sv */
`timescale 1ns/1ps
module rcp_ctrl_bench;
  import rcp_pkg::*;

  logic         mclk;
  logic         resetn;
  rcp_bus_req_s bus_req;
  logic         pwr_seq_start;
  logic         pwr_blocks_up;
  logic         sys_wake;
  logic         mirror_done;
  logic [15:0]  rdata;
  logic         core_clk_tick;
  logic         rf_clk_tick;
  rcp_pwr_s     pwr;
  logic         mirror_busy;
  logic [1:0]   mirror_bus_div;
  logic         pwr_proceed;
  logic         soft_rst_pulse;
  logic         hw_rst_pulse;
  logic         debug_port_on;
  logic         otp_ctrl_rst_req;
  logic         pin_state_hold_n;
  logic         slow_clk_sel;
  int           err_count;
  int           compares;
  int           seed;
  logic [15:0]  m_rc;
  logic [15:0]  m_pu;
  logic [15:0]  m_sc;
  logic [31:0]  addrs [5];

  rcp_ctrl #(.PWR_TIMEOUT_CYC(20), .TMO_W(16)) dut_u (
    .mclk(mclk), .resetn(resetn), .bus_req(bus_req), .pwr_seq_start(pwr_seq_start),
    .pwr_blocks_up(pwr_blocks_up), .sys_wake(sys_wake), .mirror_done(mirror_done),
    .rdata(rdata), .core_clk_tick(core_clk_tick), .rf_clk_tick(rf_clk_tick), .pwr(pwr),
    .mirror_busy(mirror_busy), .mirror_bus_div(mirror_bus_div), .pwr_proceed(pwr_proceed),
    .soft_rst_pulse(soft_rst_pulse), .hw_rst_pulse(hw_rst_pulse),
    .debug_port_on(debug_port_on), .otp_ctrl_rst_req(otp_ctrl_rst_req),
    .pin_state_hold_n(pin_state_hold_n), .slow_clk_sel(slow_clk_sel));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rd(input logic [31:0] a, output logic [15:0] d);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge mclk);
  endtask

  // Model update, then the bus write
  task automatic mw(input logic [31:0] a, input logic [15:0] d);
    if (a == RADIO_CLOCK_CTRL_OFS)
      m_rc = d & RC_WMASK;
    if (a == POWER_UNIT_CTRL_OFS)
      m_pu = d & PU_WMASK;
    if (a == SYSTEM_CTRL_OFS)
      m_sc = d & SC_WMASK;
    if (a == SYSTEM_CTRL_OFS && d[15])
    begin
      m_rc = RADIO_CLOCK_CTRL_RST;
      m_pu = POWER_UNIT_CTRL_RST;
    end
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge mclk);
    bus_req.wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rall;
    logic [15:0] d;
    logic [15:0] e;
    foreach (addrs[i])
    begin
      e = (i == 0) ? m_rc : (i == 1) ? m_pu : (i == 2) ? m_sc : 16'h0;
      rd(addrs[i], d);
      chk("rdata", d, e);
    end
  endtask

  task automatic lvl;
    chk("pwr", 16'(pwr), 16'({m_pu[11:8], m_pu[2:1], m_rc[6]}));
    chk("mdiv", 16'(mirror_bus_div), 16'(m_pu[5:4]));
    chk("sys", 16'({debug_port_on, otp_ctrl_rst_req, pin_state_hold_n, slow_clk_sel}),
        16'({m_sc[7:5], m_sc[3]}));
  endtask

  task automatic pulse_start;
    pwr_seq_start <= 1'b1;
    @(posedge mclk);
    pwr_seq_start <= 1'b0;
  endtask

  task automatic wake;
    sys_wake <= 1'b1;
    @(posedge mclk);
    sys_wake <= 1'b0;
    @(posedge mclk);
  endtask

  initial
  begin
    #2000000;
    err_count++;
    stop_test();
  end

  initial
  begin
    logic [31:0] a;
    logic [15:0] d;
    int          nc;
    int          nr;
    seed = 27234;
    err_count = 0;
    compares = 0;
    bus_req = '0;
    pwr_seq_start = 1'b0;
    pwr_blocks_up = 1'b0;
    sys_wake = 1'b0;
    mirror_done = 1'b0;
    resetn = 1'b0;
    m_rc = RADIO_CLOCK_CTRL_RST;
    m_pu = POWER_UNIT_CTRL_RST;
    m_sc = SYSTEM_CTRL_RST;
    addrs = '{RADIO_CLOCK_CTRL_OFS, POWER_UNIT_CTRL_OFS, SYSTEM_CTRL_OFS,
              ANALOG_STATUS_OFS, 32'h5000_000c};
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    rall();
    lvl();
    $display("test reset_values done");
    for (int i = 0; i < 12; i++)
    begin
      a = addrs[$unsigned($random(seed)) % 5];
      d = 16'($random(seed));
      if (a == RADIO_CLOCK_CTRL_OFS)
        d[3] = 1'b0;
      if (a == SYSTEM_CTRL_OFS)
        d[15] = 1'b0;
      mw(a, d);
      rall();
      lvl();
    end
    $display("test random_access done");
    // software side, all four divider codes swept, including codes software would not program
    for (int c = 0; c < 5; c++)
    begin
      mw(RADIO_CLOCK_CTRL_OFS, (c < 4) ? 16'h0088 | 16'(c << 4) | 16'(3 - c) : 16'h0040);
      repeat (10) @(posedge mclk);
      nc = 0;
      nr = 0;
      repeat (64)
      begin
        @(posedge mclk);
        nc += int'(core_clk_tick === 1'b1);
        nr += int'(rf_clk_tick === 1'b1);
      end
      chk("core_ticks", 16'(nc), (c < 4) ? 16'(64 >> c) : 16'h0);
      chk("rf_ticks", 16'(nr), (c < 4) ? 16'(64 >> (3 - c)) : 16'h0);
    end
    lvl();
    $display("test dividers done");
    mw(SYSTEM_CTRL_OFS, 16'h0020);
    pulse_start();
    pwr_blocks_up <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("proceed", 16'(pwr_proceed), 16'h1);
    rd(ANALOG_STATUS_OFS, d);
    chk("status_ok", d, 16'h0001);
    pwr_blocks_up <= 1'b0;
    pulse_start();
    repeat (17) @(posedge mclk);
    chk("proceed", 16'(pwr_proceed), 16'h0);
    repeat (6) @(posedge mclk);
    chk("proceed", 16'(pwr_proceed), 16'h1);
    rd(ANALOG_STATUS_OFS, d);
    chk("status_tmo", 16'(d[2:1]), 16'h1);
    mw(SYSTEM_CTRL_OFS, 16'h0220);
    pulse_start();
    repeat (40) @(posedge mclk);
    chk("proceed", 16'(pwr_proceed), 16'h0);
    rd(ANALOG_STATUS_OFS, d);
    chk("status_wait", 16'(d[2]), 16'h1);
    pwr_blocks_up <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("proceed", 16'(pwr_proceed), 16'h1);
    $display("test power_sequence done");
    mw(POWER_UNIT_CTRL_OFS, 16'h0001);
    mw(SYSTEM_CTRL_OFS, 16'h0030);
    wake();
    chk("wake", 16'({hw_rst_pulse, mirror_busy}), 16'h2);
    mw(POWER_UNIT_CTRL_OFS, 16'h0000);
    wake();
    chk("wake", 16'({hw_rst_pulse, mirror_busy}), 16'h1);
    rd(ANALOG_STATUS_OFS, d);
    chk("status_copy", 16'(d[3]), 16'h1);
    mirror_done <= 1'b1;
    @(posedge mclk);
    mirror_done <= 1'b0;
    @(posedge mclk);
    chk("copy_end", 16'(mirror_busy), 16'h0);
    mw(SYSTEM_CTRL_OFS, 16'h0034);
    wake();
    chk("wake", 16'({hw_rst_pulse, mirror_busy}), 16'h0);
    $display("test wake done");
    mw(POWER_UNIT_CTRL_OFS, 16'h0f35);
    mw(SYSTEM_CTRL_OFS, 16'h80a8);
    rall();
    lvl();
    $display("test soft_reset done");
    stop_test();
  end
endmodule
